// File: design/deac_ctrl.v
`include "deac_consts.vh"
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] software sets read_enable, then loads eeprom_addr_reg before reading
// [R2] read starts only when read_start is set while read_enable is high
// [R3] hardware clears read_start when the read ends; data then valid
// [R4] eeprom_data_reg holds until the next read or write
// [R5] software sets write_enable, loads address and data before writing
// [R6] write starts only when write_start is set while write_enable is high
// [R7] write length comes from a timer not tied to the bus timing
// [R8] hardware clears write_start when the byte is stored
// [R9] power-on clears write_enable
// [R10] power-on clears bank_pointer; control register only reachable in bank 1
// [R11] cycle end sets nvm_irq_flag and the multi-function request flag
// [R12] vector only with global, nvm, multi enables set and stack not full
// [R13] servicing clears only the multi-function flag; software clears nvm_irq_flag
// [R14] software keeps write_enable and bank_pointer cleared when idle
// [R15] software reaches the control register indirectly in bank 1
// [R16] control bits: read_start 0, read_enable 1, write_start 2, write_enable 3
// [R17] software clears control register and bank_pointer after the cycle
// [R18] eeprom_data_reg is 8-bit read/write, undefined at power-on; the code clears it to 8'h00 on reset
// [R19] software never sets both starts, nor all four bits, at once
// [R20] new start requests ignored while a cycle runs
module deac_ctrl #(
    parameter        AW       = 8,
    parameter        DEPTH    = 256,
    parameter [7:0]  WR_TICKS = `DEAC_WR_TICKS
) (
    input  wire          sys_clk_i,
    input  wire          resetn_i,
    // data register write port
    input  wire          data_wr_i,
    input  wire [7:0]    data_wdata_i,
    // address register write port
    input  wire          addr_wr_i,
    input  wire [AW-1:0] addr_wdata_i,
    // bank pointer write port
    input  wire          bank_wr_i,
    input  wire          bank_wdata_i,
    // control register access by indirect location
    input  wire          ctrl_wr_i,
    input  wire [7:0]    ctrl_loc_i,
    input  wire [3:0]    ctrl_wdata_i,
    // interrupt controls
    input  wire          irq_flag_clr_i,
    input  wire          nvm_irq_enable_i,
    input  wire          multi_enable_i,
    input  wire          global_enable_i,
    input  wire          stack_full_i,
    input  wire          irq_ack_i,
    output reg  [7:0]    eeprom_data_o,
    output reg  [AW-1:0] eeprom_addr_o,
    output reg  [3:0]    eeprom_ctrl_o,
    output reg           bank_pointer_o,
    output reg           busy_o,
    output reg           nvm_irq_flag_o,
    output reg           multi_irq_flag_o,
    output reg           irq_vector_o
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_READ = 2'b01;
    localparam [1:0] ST_WRITE = 2'b10;

    reg [7:0]    mem_reg [0:DEPTH-1];
    reg [1:0]    state_reg;
    reg [7:0]    cnt_reg;
    reg [AW-1:0] cyc_addr_reg;
    wire         tick;
    wire         ctrl_hit;
    wire         rd_go;
    wire         wr_go;
    wire         done;
    wire         rd_done;
    wire         wr_done;
    wire         vec_ok;

    deac_timer u_timer (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .tick_o    (tick)
    );

    assign ctrl_hit = ctrl_wr_i && (bank_pointer_o == `DEAC_CTRL_BANK)
                      && (ctrl_loc_i == `DEAC_CTRL_LOC); // [R10]
    assign rd_go = ctrl_hit && (state_reg == ST_IDLE)
                   && ctrl_wdata_i[`DEAC_CTL_RD_START]
                   && ctrl_wdata_i[`DEAC_CTL_RD_EN]; // [R2]
    assign wr_go = ctrl_hit && (state_reg == ST_IDLE) && !rd_go
                   && ctrl_wdata_i[`DEAC_CTL_WR_START]
                   && ctrl_wdata_i[`DEAC_CTL_WR_EN]; // [R6]
    assign done = ((state_reg == ST_READ) && (cnt_reg == 8'h00))
                  || ((state_reg == ST_WRITE) && tick && (cnt_reg == 8'h00));

    // cycle end split by kind, and the vector gate
    assign rd_done = done && (state_reg == ST_READ);
    assign wr_done = done && (state_reg == ST_WRITE);
    assign vec_ok  = global_enable_i && nvm_irq_enable_i && multi_enable_i
                     && !stack_full_i; // [R12]

    // cycle sequencer
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 8'h00;
            cyc_addr_reg  <= {AW{1'b0}};
            eeprom_ctrl_o <= 4'h0; // [R9]
            busy_o        <= 1'b0;
        end else begin
            if (ctrl_hit && (state_reg == ST_IDLE)) begin
                eeprom_ctrl_o[`DEAC_CTL_RD_EN] <= ctrl_wdata_i[`DEAC_CTL_RD_EN];
                eeprom_ctrl_o[`DEAC_CTL_WR_EN] <= ctrl_wdata_i[`DEAC_CTL_WR_EN];
                eeprom_ctrl_o[`DEAC_CTL_RD_START] <= rd_go;
                eeprom_ctrl_o[`DEAC_CTL_WR_START] <= wr_go;
            end else if (ctrl_hit) begin
                // enables may change; starts stay owned by the running cycle
                eeprom_ctrl_o[`DEAC_CTL_RD_EN] <= ctrl_wdata_i[`DEAC_CTL_RD_EN]; // [R20]
                eeprom_ctrl_o[`DEAC_CTL_WR_EN] <= ctrl_wdata_i[`DEAC_CTL_WR_EN];
            end
            case (state_reg)
                ST_IDLE: begin
                    if (rd_go) begin
                        state_reg    <= ST_READ;
                        cnt_reg      <= {4'h0, `DEAC_RD_CYCLES};
                        cyc_addr_reg <= eeprom_addr_o;
                        busy_o       <= 1'b1;
                    end else if (wr_go) begin
                        state_reg    <= ST_WRITE;
                        cnt_reg      <= WR_TICKS; // [R7]
                        cyc_addr_reg <= eeprom_addr_o;
                        busy_o       <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (done) begin
                        state_reg <= ST_IDLE;
                        busy_o    <= 1'b0;
                        eeprom_ctrl_o[`DEAC_CTL_RD_START] <= 1'b0; // [R3]
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ST_WRITE: begin
                    if (done) begin
                        state_reg <= ST_IDLE;
                        busy_o    <= 1'b0;
                        eeprom_ctrl_o[`DEAC_CTL_WR_START] <= 1'b0; // [R8]
                    end else if (tick) begin
                        cnt_reg <= cnt_reg - 8'h01; // [R7]
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_o    <= 1'b0;
                end
            endcase
        end
    end

    // array storage, written at the end of a write cycle
    always @(posedge sys_clk_i) begin
        if (wr_done) begin
            mem_reg[cyc_addr_reg] <= eeprom_data_o; // [R8]
        end
    end

    // data register: software writes, reads load it, otherwise it holds
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            eeprom_data_o <= 8'h00; // [R18]
        end else if (rd_done) begin
            eeprom_data_o <= mem_reg[cyc_addr_reg]; // [R3]
        end else if (data_wr_i && !busy_o) begin
            eeprom_data_o <= data_wdata_i; // [R4]
        end
    end

    // address register and bank pointer
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            eeprom_addr_o  <= {AW{1'b0}};
            bank_pointer_o <= 1'b0; // [R10]
        end else begin
            if (addr_wr_i) begin
                eeprom_addr_o <= addr_wdata_i;
            end
            if (bank_wr_i) begin
                bank_pointer_o <= bank_wdata_i;
            end
        end
    end

    // completion interrupt
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nvm_irq_flag_o   <= 1'b0;
            multi_irq_flag_o <= 1'b0;
        end else begin
            if (done) begin
                nvm_irq_flag_o <= 1'b1; // [R11]
            end else if (irq_flag_clr_i) begin
                nvm_irq_flag_o <= 1'b0; // [R13]
            end
            if (done) begin
                multi_irq_flag_o <= 1'b1; // [R11]
            end else if (irq_ack_i) begin
                multi_irq_flag_o <= 1'b0; // [R13]
            end
        end
    end

    // vector request follows its conditions one cycle late, dropped on acknowledge
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_vector_o <= 1'b0;
        end else begin
            irq_vector_o <= vec_ok && multi_irq_flag_o && nvm_irq_flag_o
                            && !irq_ack_i; // [R12]
        end
    end
endmodule // deac_ctrl
`default_nettype wire

// File: design/deac_consts.vh
`ifndef DEAC_CONSTS_VH
`define DEAC_CONSTS_VH
// control register bit positions
`define DEAC_CTL_RD_START   0
`define DEAC_CTL_RD_EN      1
`define DEAC_CTL_WR_START   2
`define DEAC_CTL_WR_EN      3
// bank holding the control register
`define DEAC_CTRL_BANK      1'b1
// index of the control register within bank 1
`define DEAC_CTRL_LOC       8'h40
// read countdown load; a read takes one cycle more than this in the array
`define DEAC_RD_CYCLES      4'h2
// default write timer ticks (slow timer enables)
`define DEAC_WR_TICKS       8'h20
// terminal count of the internal write timer divider; the tick period is this plus one system clock
`define DEAC_TMR_DIV        8'h1f
`endif

// File: design/deac_timer.v
`include "deac_consts.vh"
`timescale 1ns/1ps
`default_nettype none
// free-running divider producing the write timer tick
module deac_timer #(
    parameter [7:0] DIV = `DEAC_TMR_DIV
) (
    input  wire       sys_clk_i,
    input  wire       resetn_i,
    output reg        tick_o
);
    reg [7:0] cnt_reg;
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 8'h00;
            tick_o  <= 1'b0;
        end else if (cnt_reg == DIV) begin
            cnt_reg <= 8'h00;
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            tick_o  <= 1'b0;
        end
    end
endmodule // deac_timer
`default_nettype wire

// File: tb/deac_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module deac_ctrl_checker (
    input wire logic       sys_clk_i,
    input wire logic       resetn_i,
    input wire logic       ctrl_wr_i,
    input wire logic [7:0] ctrl_loc_i,
    input wire logic [3:0] ctrl_wdata_i,
    input wire logic       data_wr_i,
    input wire logic       irq_flag_clr_i,
    input wire logic       nvm_irq_enable_i,
    input wire logic       multi_enable_i,
    input wire logic       global_enable_i,
    input wire logic       stack_full_i,
    input wire logic       irq_ack_i,
    input wire logic [7:0] eeprom_data_o,
    input wire logic [3:0] eeprom_ctrl_o,
    input wire logic       bank_pointer_o,
    input wire logic       busy_o,
    input wire logic       nvm_irq_flag_o,
    input wire logic       multi_irq_flag_o,
    input wire logic       irq_vector_o
);
    wire acc = ctrl_wr_i && bank_pointer_o && ctrl_loc_i == 8'h40;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_RD_GO: assert property (acc && !busy_o && ctrl_wdata_i[1:0] == 2'b11
        |=> eeprom_ctrl_o[0] && busy_o) else $error("read did not start");
    AST_RD_END: assert property ($rose(eeprom_ctrl_o[0]) |-> ##3 !eeprom_ctrl_o[0] && !busy_o)
        else $error("read end wrong");
    AST_DATA_HOLD: assert property (!busy_o && !data_wr_i |=> $stable(eeprom_data_o))
        else $error("data changed");
    AST_GATE: assert property (!busy_o && !acc |=> $stable(eeprom_ctrl_o))
        else $error("control changed");
    AST_IRQ_SET: assert property ($fell(busy_o) |-> nvm_irq_flag_o && multi_irq_flag_o)
        else $error("flags not set");
    AST_VEC: assert property (irq_vector_o |-> $past(global_enable_i && nvm_irq_enable_i
        && multi_enable_i && !stack_full_i && nvm_irq_flag_o && multi_irq_flag_o))
        else $error("bad vector");
    AST_ACK: assert property (irq_ack_i && !irq_flag_clr_i && !busy_o
        |=> !multi_irq_flag_o && $stable(nvm_irq_flag_o)) else $error("bad ack");
    AST_NO_RESTART: assert property (busy_o |=> eeprom_ctrl_o[0] <= $past(eeprom_ctrl_o[0])
        && eeprom_ctrl_o[2] <= $past(eeprom_ctrl_o[2])) else $error("start while busy");
    cover property ($fell(busy_o));
    cover property (irq_vector_o);
    cover property (irq_ack_i && multi_irq_flag_o);
endmodule // deac_ctrl_checker
bind deac_ctrl deac_ctrl_checker u_chk (
    .sys_clk_i        (sys_clk_i),
    .resetn_i         (resetn_i),
    .ctrl_wr_i        (ctrl_wr_i),
    .ctrl_loc_i       (ctrl_loc_i),
    .ctrl_wdata_i     (ctrl_wdata_i),
    .data_wr_i        (data_wr_i),
    .irq_flag_clr_i   (irq_flag_clr_i),
    .nvm_irq_enable_i (nvm_irq_enable_i),
    .multi_enable_i   (multi_enable_i),
    .global_enable_i  (global_enable_i),
    .stack_full_i     (stack_full_i),
    .irq_ack_i        (irq_ack_i),
    .eeprom_data_o    (eeprom_data_o),
    .eeprom_ctrl_o    (eeprom_ctrl_o),
    .bank_pointer_o   (bank_pointer_o),
    .busy_o           (busy_o),
    .nvm_irq_flag_o   (nvm_irq_flag_o),
    .multi_irq_flag_o (multi_irq_flag_o),
    .irq_vector_o     (irq_vector_o)
);
`default_nettype wire

// File: tb/data_eeprom_access_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_controller_tb_top;
    logic       clk = 0, rstn = 0;
    logic [5:0] st = 0;
    logic [7:0] v = 0, loc = 8'h40;
    logic [3:0] en = 0;
    int         failures = 0, total_checks = 0, cyc = 0, n;
    wire  [7:0] dat, adr;
    wire  [3:0] ctl;
    wire        bank, busy, nflag, mflag, vec;
    deac_ctrl #(.WR_TICKS(8'h02)) DUT (.sys_clk_i(clk), .resetn_i(rstn), .data_wr_i(st[0]),
        .data_wdata_i(v), .addr_wr_i(st[1]), .addr_wdata_i(v), .bank_wr_i(st[2]),
        .bank_wdata_i(v[0]), .ctrl_wr_i(st[3]), .ctrl_loc_i(loc), .ctrl_wdata_i(v[3:0]),
        .irq_flag_clr_i(st[4]), .nvm_irq_enable_i(en[0]), .multi_enable_i(en[1]),
        .global_enable_i(en[2]), .stack_full_i(en[3]), .irq_ack_i(st[5]),
        .eeprom_data_o(dat), .eeprom_addr_o(adr), .eeprom_ctrl_o(ctl), .bank_pointer_o(bank),
        .busy_o(busy), .nvm_irq_flag_o(nflag), .multi_irq_flag_o(mflag), .irq_vector_o(vec));
    initial forever #5 clk = ~clk;
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_sim;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tk(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // one-cycle strobe k: 0 data, 1 addr, 2 bank, 3 ctrl, 4 flag clear, 5 ack
    task automatic wr(input int k, input logic [7:0] d);
        tk(1);
        st[k] = 1'b1;
        v = d;
        tk(1);
        st = 6'h00;
    endtask
    task automatic t_prot;
        chk({4'h0, ctl}, 8'h00);
        chk({7'h0, bank}, 8'h00);
        wr(3, 8'h0c);
        chk({4'h0, ctl}, 8'h00);
        wr(2, 8'h01);
        loc = 8'h41;
        wr(3, 8'h0c);
        chk({4'h0, ctl}, 8'h00);
        loc = 8'h40;
    endtask
    task automatic t_write;
        wr(3, 8'h04);
        chk({4'h0, ctl}, 8'h00);
        wr(3, 8'h08);
        wr(1, 8'h12);
        wr(0, 8'ha5);
        wr(3, 8'h0c);
        chk({3'h0, busy, ctl}, 8'h1c);
        wr(0, 8'h3c);
        wr(3, 8'h0b);
        chk({4'h0, ctl}, 8'h0e);
        chk(dat, 8'ha5);
        n = 0;
        while (ctl[2] === 1'b1 && n < 2000) begin
            tk(1);
            n++;
        end
        chk({7'h0, n >= 32'h20}, 8'h01);
        chk({4'h0, ctl}, 8'h0a);
        chk({6'h0, nflag, mflag}, 8'h03);
        chk(adr, 8'h12);
    endtask
    task automatic t_irq;
        en = 4'b0111;
        tk(2);
        chk({7'h0, vec}, 8'h01);
        en = 4'b1111;
        tk(2);
        chk({7'h0, vec}, 8'h00);
        en = 4'b0011;
        wr(5, 8'h00);
        chk({6'h0, nflag, mflag}, 8'h02);
        wr(4, 8'h00);
        chk({6'h0, nflag, mflag}, 8'h00);
    endtask
    task automatic t_read;
        wr(3, 8'h00);
        wr(0, 8'h5a);
        wr(3, 8'h01);
        chk({4'h0, ctl}, 8'h00);
        wr(3, 8'h02);
        wr(1, 8'h12);
        wr(3, 8'h03);
        chk({3'h0, busy, ctl}, 8'h13);
        tk(2);
        chk({4'h0, ctl}, 8'h03);
        tk(1);
        chk({3'h0, busy, ctl}, 8'h02);
        chk(dat, 8'ha5);
        chk({6'h0, nflag, mflag}, 8'h03);
        tk(5);
        chk(dat, 8'ha5);
        wr(3, 8'h00);
        wr(2, 8'h00);
        chk({3'h0, bank, ctl}, 8'h00);
        wr(3, 8'h0c);
        chk({3'h0, busy, ctl}, 8'h00);
    endtask
    initial begin
        tk(20);
        rstn = 1'b1;
        t_prot;
        t_write;
        t_irq;
        t_read;
        end_sim;
    end
endmodule // data_eeprom_access_controller_tb_top
`default_nettype wire
